/* File: verilog/rere_consts.vh */
// Constants for the rotate-via-extend and return execution block.
// Assumes a byte-addressed Avalon-MM slave window with one word per register.
`ifndef RERE_CONSTS_VH
`define RERE_CONSTS_VH

// Register byte offsets
`define RERE_REG_CTRL 8'h00
`define RERE_REG_EXT 8'h04
`define RERE_REG_OPERAND 8'h08
`define RERE_REG_CNTREG 8'h0c
`define RERE_REG_EA_ADDR 8'h10
`define RERE_REG_SP 8'h14
`define RERE_REG_PC 8'h18
`define RERE_REG_STATUS_REGISTER 8'h1c
`define RERE_REG_STATE 8'h20
`define RERE_REG_RESULT 8'h24

// Reset values
`define RERE_RST_SP 32'h0000_0000
`define RERE_RST_PC 32'h0000_0000
`define RERE_RST_SR 16'h2700

// status_register field positions
`define RERE_SR_C 0
`define RERE_SR_V 1
`define RERE_SR_Z 2
`define RERE_SR_N 3
`define RERE_SR_X 4
`define RERE_SR_S 13

// State register bit positions
`define RERE_ST_BUSY 0
`define RERE_ST_DONE 1
`define RERE_ST_TRAP 2
`define RERE_ST_FMT_ERR 3
`define RERE_ST_ILLEGAL 4
`define RERE_ST_RESUME 5

// Opcodes of the return group
`define RERE_OP_EXC_RET 16'h4e73
`define RERE_OP_RET_DEALLOC 16'h4e74
`define RERE_OP_RET_SUB 16'h4e75
`define RERE_OP_RET_FLAGS 16'h4e77

// Rotate opcode signatures
`define RERE_OP_ROT_REG_TOP 4'he
`define RERE_OP_ROT_REG_KIND 2'b10
`define RERE_OP_ROT_MEM_TOP 7'h72
`define RERE_SIZE_BYTE 2'b00
`define RERE_SIZE_WORD 2'b01
`define RERE_SIZE_LONG 2'b10
`define RERE_SIZE_MEMFORM 2'b11

`endif

/* File: verilog/rere_rotx.v */
// One-position rotate through extend over byte, word or long width.
// Purely combinational; bits above the operand width pass unchanged.
`timescale 1ns/1ps
`include "rere_consts.vh"

module rere_rotx (
	input wire [31:0] i_data, // Operand before the step
	input wire i_x, // Extend value entering the operand
	input wire [1:0] i_size, // Operand width code
	input wire i_left, // High for a left step
	output reg [31:0] o_data, // Operand after the step
	output reg o_x // Bit that left the operand
);

	// Left: top bit leaves, old extend enters bit 0; right is the mirror
	always @* begin
		case (i_size)
		`RERE_SIZE_BYTE: begin
			o_x = i_left ? i_data[7] : i_data[0];
			o_data = i_left ? {i_data[31:8], i_data[6:0], i_x} // [RQ1]
				: {i_data[31:8], i_x, i_data[7:1]}; // [RQ2]
		end
		`RERE_SIZE_WORD: begin
			o_x = i_left ? i_data[15] : i_data[0];
			o_data = i_left ? {i_data[31:16], i_data[14:0], i_x} // [RQ1]
				: {i_data[31:16], i_x, i_data[15:1]}; // [RQ2]
		end
		default: begin
			o_x = i_left ? i_data[31] : i_data[0];
			o_data = i_left ? {i_data[30:0], i_x} : {i_x, i_data[31:1]}; // [RQ1] [RQ2]
		end
		endcase
	end

endmodule // rere_rotx

/* File: verilog/rere_fmt.v */
// Stack frame format decoder for the exception return.
// Combinational; the caller holds the format word stable.
`timescale 1ns/1ps

module rere_fmt (
	input wire [3:0] i_fmt, // Format code from the format word
	output reg [5:0] o_words, // Frame length in 16-bit words
	output reg o_valid, // Format supported
	output reg o_load_pc, // Frame reloads the program counter
	output reg o_throwaway, // Continue on the active system stack
	output reg o_resume // Interrupted instruction resumes
);

	// Frame sizes include the format word itself
	always @* begin
		o_words = 6'h00;
		o_valid = 1'b1;
		o_load_pc = 1'b1;
		o_throwaway = 1'b0;
		o_resume = 1'b0;
		case (i_fmt)
		4'h0: o_words = 6'h04; // [RQ15]
		4'h1: begin
			o_words = 6'h04; // [RQ16]
			o_load_pc = 1'b0;
			o_throwaway = 1'b1;
		end
		4'h2: o_words = 6'h06; // [RQ17]
		4'h9: begin
			o_words = 6'h0a; // [RQ18]
			o_resume = 1'b1;
		end
		4'ha: begin
			o_words = 6'h10; // [RQ19]
			o_resume = 1'b1;
		end
		4'hb: begin
			o_words = 6'h2e; // [RQ19]
			o_resume = 1'b1;
		end
		default: begin
			o_valid = 1'b0; // [RQ20]
			o_load_pc = 1'b0;
		end
		endcase
	end

endmodule // rere_fmt

/* File: verilog/rere_exec.v */
// Execution engine for rotate-via-extend and the four stack returns.
// Assumes an Avalon-MM master for control and a word-wide memory with req/ack.
// Functional notes
// [RQ1] Left rotate: top bit goes to carry and extend, old extend enters bit 0.
// [RQ2] Right rotate: bit 0 goes to carry and extend, old extend enters top.
// [RQ3] Immediate count field 1..7 means that many, 0 means eight.
// [RQ4] Register count comes from the named data register, modulo 64.
// [RQ5] Memory operand rotates exactly one position, word width.
// [RQ6] Size field: 00 byte, 01 word, 10 long.
// [RQ7] Direction bit: 0 right, 1 left, both forms.
// [RQ8] Count location bit: 0 immediate field, 1 data register.
// [RQ9] Extend gets last bit out; unchanged when count is zero.
// [RQ10] Carry gets last bit out; copies extend when count is zero.
// [RQ11] Negative from result top bit, zero on all-zero result, overflow cleared.
// [RQ12] Memory form accepts only memory alterable addressing modes.
// [RQ13] Return-and-deallocate pops PC, then SP gets SP plus 4 plus displacement.
// [RQ14] Exception return is privileged: pops status, PC, frame; traps in user state.
// [RQ15] Format 0000: four words, loads status and PC.
// [RQ16] Format 0001: four words, status only, then continues on system stack.
// [RQ17] Format 0010: six words, loads status and PC, rest discarded.
// [RQ18] Format 1001: ten words, coprocessor instruction resumes.
// [RQ19] Format 1010 removes sixteen words, 1011 forty-six; instruction resumes.
// [RQ20] Format 1000 or any unlisted code raises a format error.
// [RQ21] Flag return pops condition byte then PC; supervisor byte kept.
// [RQ22] Subroutine return pops PC, SP plus four.
`timescale 1ns/1ps
`include "rere_consts.vh"

module rere_exec (
	input wire i_core_clk, // Core clock, 125 MHz
	input wire i_sys_rst, // Asynchronous reset, active high
	input wire [7:0] i_av_address, // Avalon byte address
	input wire i_av_read, // Avalon read request
	input wire i_av_write, // Avalon write request
	input wire [31:0] i_av_writedata, // Avalon write data
	input wire [3:0] i_av_byteenable, // Avalon byte lanes
	output reg [31:0] o_av_readdata, // Avalon read data
	output reg o_av_waitrequest, // Avalon wait, low on answer
	output reg o_mem_req, // Memory request level
	output reg o_mem_we, // Memory write when high
	output reg [31:0] o_mem_addr, // Memory byte address
	output reg [15:0] o_mem_wdata, // Memory write word
	input wire i_mem_ack, // Memory answer pulse
	input wire [15:0] i_mem_rdata, // Memory read word
	output reg o_busy // Instruction in progress
);

	localparam S_IDLE = 3'd0;
	localparam S_DEC = 3'd1;
	localparam S_ROT = 3'd2;
	localparam S_MRD = 3'd3;
	localparam S_MWR = 3'd4;
	localparam S_POP = 3'd5;
	localparam S_FIN = 3'd6;

	localparam K_ROTR = 3'd0;
	localparam K_ROTM = 3'd1;
	localparam K_RTS = 3'd2;
	localparam K_RTD = 3'd3;
	localparam K_RTR = 3'd4;
	localparam K_RTE = 3'd5;

	reg [2:0] state;
	reg [2:0] kind;
	reg [15:0] op;
	reg [15:0] ext;
	reg [31:0] operand;
	reg [31:0] cntreg;
	reg [31:0] ea_addr;
	reg [31:0] sp;
	reg [31:0] pc;
	reg [15:0] status_register;
	reg [31:0] result;
	reg done;
	reg trap;
	reg fmt_err;
	reg illegal;
	reg resume;
	reg [6:0] cnt;
	reg [31:0] work;
	reg wx;
	reg [1:0] size;
	reg dir;
	reg [2:0] popn;
	reg [2:0] idx;
	reg [15:0] popw [0:3];

	wire [31:0] step_data;
	wire step_x;
	wire [5:0] fr_words;
	wire fr_valid;
	wire fr_load_pc;
	wire fr_throwaway;
	wire fr_resume;

	// Decoded opcode fields
	wire [1:0] op_size = op[7:6];
	wire op_dir = op[8];
	wire op_reg_cnt = op[5];
	wire [2:0] op_cnt = op[11:9];
	wire [2:0] ea_mode = op[5:3];
	wire [2:0] ea_reg = op[2:0];
	wire is_rot_reg = (op[15:12] == `RERE_OP_ROT_REG_TOP) && (op[4:3] == `RERE_OP_ROT_REG_KIND)
		&& (op_size != `RERE_SIZE_MEMFORM);
	wire is_rot_mem = (op[15:9] == `RERE_OP_ROT_MEM_TOP) && (op_size == `RERE_SIZE_MEMFORM);
	// Register direct, immediate and PC-relative modes fall outside this set
	wire ea_ok = ((ea_mode >= 3'b010) && (ea_mode <= 3'b110))
		|| ((ea_mode == 3'b111) && (ea_reg[2:1] == 2'b00)); // [RQ12]

	// Result top bit and zero test at the operand width
	reg res_msb;
	reg res_zero;
	always @* begin
		case (size)
		`RERE_SIZE_BYTE: begin
			res_msb = work[7];
			res_zero = (work[7:0] == 8'h00);
		end
		`RERE_SIZE_WORD: begin
			res_msb = work[15];
			res_zero = (work[15:0] == 16'h0000);
		end
		default: begin
			res_msb = work[31];
			res_zero = (work == 32'h0000_0000);
		end
		endcase
	end

	// Immediate count: zero field means eight
	wire [6:0] imm_cnt = (op_cnt == 3'b000) ? 7'h08 : {4'h0, op_cnt}; // [RQ3]
	// Register count: low six bits give modulo 64
	wire [6:0] reg_cnt = {1'b0, cntreg[5:0]}; // [RQ4]
	wire [15:0] pop_top = popw[0];
	wire [31:0] pop_pc_a = {popw[0], popw[1]};
	wire [31:0] pop_pc_b = {popw[1], popw[2]};
	wire [31:0] ext_sx = {{16{ext[15]}}, ext};
	wire [31:0] fr_bytes = {25'h0, fr_words, 1'b0};

	rere_rotx u_rotx (
		.i_data(work),
		.i_x(wx),
		.i_size(size),
		.i_left(dir),
		.o_data(step_data),
		.o_x(step_x)
	);

	rere_fmt u_fmt (
		.i_fmt(popw[3][15:12]),
		.o_words(fr_words),
		.o_valid(fr_valid),
		.o_load_pc(fr_load_pc),
		.o_throwaway(fr_throwaway),
		.o_resume(fr_resume)
	);

	// Byte-lane merge for register writes
	function [31:0] be_merge;
		input [31:0] old_v;
		input [31:0] new_v;
		input [3:0] be;
		integer b;
		begin
			be_merge = old_v;
			for (b = 0; b < 4; b = b + 1) begin
				if (be[b])
					be_merge[b*8 +: 8] = new_v[b*8 +: 8];
			end
		end
	endfunction

	// Bus answer: one wait cycle, then waitrequest low for one cycle
	wire av_req = i_av_read | i_av_write;
	wire av_wr_now = i_av_write & ~o_av_waitrequest;
	wire idle = (state == S_IDLE);

	always @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_av_waitrequest <= 1'b1;
			o_av_readdata <= 32'h0000_0000;
		end else if (av_req && o_av_waitrequest) begin
			o_av_waitrequest <= 1'b0;
			case (i_av_address)
			`RERE_REG_CTRL: o_av_readdata <= {16'h0000, op};
			`RERE_REG_EXT: o_av_readdata <= {16'h0000, ext};
			`RERE_REG_OPERAND: o_av_readdata <= operand;
			`RERE_REG_CNTREG: o_av_readdata <= cntreg;
			`RERE_REG_EA_ADDR: o_av_readdata <= ea_addr;
			`RERE_REG_SP: o_av_readdata <= sp;
			`RERE_REG_PC: o_av_readdata <= pc;
			`RERE_REG_STATUS_REGISTER: o_av_readdata <= {16'h0000, status_register};
			`RERE_REG_STATE: o_av_readdata <= {26'h0, resume, illegal, fmt_err, trap, done, o_busy};
			`RERE_REG_RESULT: o_av_readdata <= result;
			default: o_av_readdata <= 32'h0000_0000;
			endcase
		end else begin
			o_av_waitrequest <= 1'b1;
		end
	end

	// Engine and software-visible state; bus writes land only while idle
	always @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			state <= S_IDLE;
			kind <= K_ROTR;
			op <= 16'h0000;
			ext <= 16'h0000;
			operand <= 32'h0000_0000;
			cntreg <= 32'h0000_0000;
			ea_addr <= 32'h0000_0000;
			sp <= `RERE_RST_SP;
			pc <= `RERE_RST_PC;
			status_register <= `RERE_RST_SR;
			result <= 32'h0000_0000;
			done <= 1'b0;
			trap <= 1'b0;
			fmt_err <= 1'b0;
			illegal <= 1'b0;
			resume <= 1'b0;
			cnt <= 7'h00;
			work <= 32'h0000_0000;
			wx <= 1'b0;
			size <= 2'b00;
			dir <= 1'b0;
			popn <= 3'd0;
			idx <= 3'd0;
			popw[0] <= 16'h0000;
			popw[1] <= 16'h0000;
			popw[2] <= 16'h0000;
			popw[3] <= 16'h0000;
			o_mem_req <= 1'b0;
			o_mem_we <= 1'b0;
			o_mem_addr <= 32'h0000_0000;
			o_mem_wdata <= 16'h0000;
			o_busy <= 1'b0;
		end else begin
			case (state)
			S_IDLE: begin
				if (av_wr_now) begin
					case (i_av_address)
					`RERE_REG_CTRL: begin
						op <= i_av_writedata[15:0];
						done <= 1'b0;
						trap <= 1'b0;
						fmt_err <= 1'b0;
						illegal <= 1'b0;
						resume <= 1'b0;
						o_busy <= 1'b1;
						state <= S_DEC;
					end
					`RERE_REG_EXT: ext <= {i_av_byteenable[1] ? i_av_writedata[15:8] : ext[15:8],
						i_av_byteenable[0] ? i_av_writedata[7:0] : ext[7:0]};
					`RERE_REG_OPERAND: operand <= be_merge(operand, i_av_writedata, i_av_byteenable);
					`RERE_REG_CNTREG: cntreg <= be_merge(cntreg, i_av_writedata, i_av_byteenable);
					`RERE_REG_EA_ADDR: ea_addr <= be_merge(ea_addr, i_av_writedata, i_av_byteenable);
					`RERE_REG_SP: sp <= be_merge(sp, i_av_writedata, i_av_byteenable);
					`RERE_REG_PC: pc <= be_merge(pc, i_av_writedata, i_av_byteenable);
					`RERE_REG_STATUS_REGISTER: status_register <= i_av_writedata[15:0];
					default: ;
					endcase
				end
			end
			S_DEC: begin
				if (is_rot_reg) begin
					kind <= K_ROTR;
					size <= op_size; // [RQ6]
					dir <= op_dir; // [RQ7]
					cnt <= op_reg_cnt ? reg_cnt : imm_cnt; // [RQ8]
					work <= operand;
					wx <= status_register[`RERE_SR_X];
					state <= S_ROT;
				end else if (is_rot_mem) begin
					if (ea_ok) begin
						kind <= K_ROTM;
						size <= `RERE_SIZE_WORD; // [RQ5]
						dir <= op_dir; // [RQ7]
						cnt <= 7'h01; // [RQ5]
						wx <= status_register[`RERE_SR_X];
						o_mem_req <= 1'b1;
						o_mem_we <= 1'b0;
						o_mem_addr <= ea_addr;
						state <= S_MRD;
					end else begin
						illegal <= 1'b1; // [RQ12]
						state <= S_FIN;
					end
				end else if (op == `RERE_OP_RET_SUB || op == `RERE_OP_RET_DEALLOC
					|| op == `RERE_OP_RET_FLAGS
					|| (op == `RERE_OP_EXC_RET && status_register[`RERE_SR_S])) begin
					case (op)
					`RERE_OP_RET_SUB: kind <= K_RTS;
					`RERE_OP_RET_DEALLOC: kind <= K_RTD;
					`RERE_OP_RET_FLAGS: kind <= K_RTR;
					default: kind <= K_RTE;
					endcase
					popn <= (op == `RERE_OP_RET_FLAGS) ? 3'd3
						: (op == `RERE_OP_EXC_RET) ? 3'd4 : 3'd2;
					idx <= 3'd0;
					o_mem_req <= 1'b1;
					o_mem_we <= 1'b0;
					o_mem_addr <= sp;
					state <= S_POP;
				end else begin
					// User-state exception return traps, anything else is illegal here
					trap <= (op == `RERE_OP_EXC_RET); // [RQ14]
					illegal <= (op != `RERE_OP_EXC_RET);
					kind <= K_ROTR;
					state <= S_FIN;
				end
			end
			S_ROT: begin
				if (cnt != 7'h00) begin
					work <= step_data; // [RQ1] [RQ2]
					wx <= step_x;
					cnt <= cnt - 7'h01;
				end else begin
					// wx still holds old extend when nothing rotated
					status_register[`RERE_SR_X] <= wx; // [RQ9]
					status_register[`RERE_SR_C] <= wx; // [RQ10]
					status_register[`RERE_SR_N] <= res_msb; // [RQ11]
					status_register[`RERE_SR_Z] <= res_zero; // [RQ11]
					status_register[`RERE_SR_V] <= 1'b0; // [RQ11]
					result <= work;
					if (kind == K_ROTM) begin
						o_mem_req <= 1'b1;
						o_mem_we <= 1'b1;
						o_mem_wdata <= work[15:0];
						state <= S_MWR;
					end else begin
						state <= S_FIN;
					end
				end
			end
			S_MRD: begin
				if (i_mem_ack) begin
					o_mem_req <= 1'b0;
					work <= {16'h0000, i_mem_rdata};
					state <= S_ROT;
				end
			end
			S_MWR: begin
				if (i_mem_ack) begin
					o_mem_req <= 1'b0;
					o_mem_we <= 1'b0;
					state <= S_FIN;
				end
			end
			S_POP: begin
				// Stack words come in ascending address order
				if (i_mem_ack) begin
					popw[idx[1:0]] <= i_mem_rdata;
					if (idx == popn - 3'd1) begin
						o_mem_req <= 1'b0;
						state <= S_FIN;
						done <= 1'b0;
					end else begin
						idx <= idx + 3'd1;
						o_mem_addr <= o_mem_addr + 32'h0000_0002;
					end
				end
			end
			default: begin
				// S_FIN commits return effects once every stack word is in
				state <= S_IDLE;
				o_busy <= 1'b0;
				done <= 1'b1;
				if (o_mem_req == 1'b0 && !illegal && !trap) begin
					case (kind)
					K_RTS: begin
						pc <= pop_pc_a; // [RQ22]
						sp <= sp + 32'h0000_0004; // [RQ22]
					end
					K_RTD: begin
						pc <= pop_pc_a; // [RQ13]
						sp <= sp + 32'h0000_0004 + ext_sx; // [RQ13]
					end
					K_RTR: begin
						status_register[7:0] <= pop_top[7:0]; // [RQ21]
						pc <= pop_pc_b; // [RQ21]
						sp <= sp + 32'h0000_0006; // [RQ21]
					end
					K_RTE: begin
						if (!fr_valid) begin
							fmt_err <= 1'b1; // [RQ20]
						end else begin
							status_register <= pop_top; // [RQ14]
							if (fr_load_pc)
								pc <= pop_pc_b; // [RQ14]
							sp <= sp + fr_bytes; // [RQ15] [RQ17] [RQ18] [RQ19]
							resume <= fr_resume; // [RQ18] [RQ19]
							if (fr_throwaway) begin
								// Rerun on the stack the new status selects
								state <= S_DEC; // [RQ16]
								o_busy <= 1'b1;
								done <= 1'b0;
							end
						end
					end
					default: ;
					endcase
				end
			end
			endcase
		end
	end

endmodule // rere_exec

/* File: verification/rere_exec_monitor.sv */
// Port checker for the rotate and return engine.
// Bound to rere_exec; sees only that module's ports.
`timescale 1ns/1ps
module rere_exec_monitor (
	input wire i_core_clk, // Core clock
	input wire i_sys_rst, // Async reset
	input wire i_av_read, // Bus read
	input wire i_av_write, // Bus write
	input wire [31:0] o_av_readdata, // Bus read data
	input wire o_av_waitrequest, // Bus wait
	input wire o_mem_req, // Memory request
	input wire o_mem_we, // Memory write
	input wire [31:0] o_mem_addr, // Memory address
	input wire i_mem_ack, // Memory answer
	input wire o_busy // Engine busy
);
	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (i_sys_rst);
	// One low cycle, then back at rest
	sequence s_av_answer;
		!o_av_waitrequest ##1 o_av_waitrequest;
	endsequence
	// A read word taken while more words follow
	sequence s_pop_taken;
		o_mem_req && i_mem_ack && !o_mem_we ##1 o_mem_req && !o_mem_we;
	endsequence
	a_bus_one_wait: assert property ((i_av_read || i_av_write) && o_av_waitrequest |=> s_av_answer)
		else $error("bus answer is not one wait cycle");
	a_bus_rest: assert property (!i_av_read && !i_av_write && o_av_waitrequest |=> o_av_waitrequest)
		else $error("waitrequest dropped with no request");
	a_data_hold: assert property (!i_av_read && !i_av_write |=> $stable(o_av_readdata))
		else $error("read data moved between accesses");
	a_req_hold: assert property (o_mem_req && !i_mem_ack |=>
		o_mem_req && $stable(o_mem_addr) && $stable(o_mem_we))
		else $error("memory request changed before its answer");
	a_pop_step: assert property (s_pop_taken |-> o_mem_addr == $past(o_mem_addr) + 32'h2)
		else $error("stack word address did not step by two");
	a_read_first: assert property ($rose(o_mem_req) && o_mem_we |->
		$past(i_mem_ack, 3) && !$past(o_mem_we, 3))
		else $error("operand write without its read three cycles before");
	a_write_last: assert property (o_mem_req && o_mem_we && i_mem_ack |=> !o_mem_req)
		else $error("memory access after the operand write");
	a_mem_busy: assert property (o_mem_req |-> o_busy)
		else $error("memory request while idle");
endmodule // rere_exec_monitor

/* File: verification/rere_stack_mem.sv */
// Word-wide stack and operand memory on the engine's far side.
// Assumes requests are held until the one-cycle answer pulse.
`timescale 1ns/1ps
module rere_stack_mem (
	input wire i_core_clk, // Core clock
	input wire i_mem_req, // Request level
	input wire i_mem_we, // Write when high
	input wire [31:0] i_mem_addr, // Byte address
	input wire [15:0] i_mem_wdata, // Write word
	input wire [3:0] i_delay, // Wait cycles before answering
	output reg o_mem_ack, // Answer pulse
	output reg [15:0] o_mem_rdata // Read word
);
	reg [15:0] mem [0:1023];
	reg [3:0] wait_cnt;
	initial begin
		o_mem_ack = 1'b0;
		o_mem_rdata = 16'h0000;
		wait_cnt = 4'h0;
	end
	// Answer after the set wait; data is valid only with the pulse
	always @(posedge i_core_clk) begin
		if (o_mem_ack) begin
			o_mem_ack <= 1'b0;
			o_mem_rdata <= ~o_mem_rdata; // Stale word must not look valid
		end else if (i_mem_req && wait_cnt >= i_delay) begin
			o_mem_ack <= 1'b1;
			wait_cnt <= 4'h0;
			o_mem_rdata <= mem[i_mem_addr[10:1]];
			if (i_mem_we)
				mem[i_mem_addr[10:1]] <= i_mem_wdata;
		end else if (i_mem_req) begin
			wait_cnt <= wait_cnt + 4'h1;
		end
	end
endmodule // rere_stack_mem

/* File: verification/tb_rere_exec.sv */
// Self-checking bench for rere_exec: rotates, memory form and returns.
// Assumes rere_stack_mem as memory and the checker bound at the foot.
`timescale 1ns/1ps
`include "rere_consts.vh"
module tb_rere_exec;
	reg clk, rst, av_rd, av_wr;
	reg [7:0] av_addr;
	reg [31:0] av_wdata, rd, e;
	reg [3:0] dly, f;
	reg [31:0] fl;
	reg [47:0] wl;
	wire [31:0] av_rdata, mem_addr;
	wire waitreq, mem_req, mem_we, mem_ack, busy;
	wire [15:0] mem_wdata, mem_rdata;
	integer n_fail, samples_checked, i;
	rere_exec u_rere_exec (.i_core_clk(clk), .i_sys_rst(rst), .i_av_address(av_addr),
		.i_av_read(av_rd), .i_av_write(av_wr), .i_av_writedata(av_wdata),
		.i_av_byteenable(4'hf), .o_av_readdata(av_rdata), .o_av_waitrequest(waitreq),
		.o_mem_req(mem_req), .o_mem_we(mem_we), .o_mem_addr(mem_addr),
		.o_mem_wdata(mem_wdata), .i_mem_ack(mem_ack), .i_mem_rdata(mem_rdata), .o_busy(busy));
	rere_stack_mem u_rere_stack_mem (.i_core_clk(clk), .i_mem_req(mem_req), .i_mem_we(mem_we),
		.i_mem_addr(mem_addr), .i_mem_wdata(mem_wdata), .i_delay(dly), .o_mem_ack(mem_ack),
		.o_mem_rdata(mem_rdata));
	// Verdict and end of run
	task conclude;
		begin
			$display("checked %0d mismatches %0d", samples_checked, n_fail);
			if (n_fail == 0 && samples_checked > 0)
				$display("[ PASS ]");
			else
				$display("[ FAIL ]");
			$finish;
		end
	endtask
	task chk(input [8*12-1:0] nm, input [31:0] exp, input [31:0] got);
		begin
			samples_checked = samples_checked + 1;
			if (got !== exp) begin
				n_fail = n_fail + 1;
				$display("Error %0s expected %h seen %h", nm, exp, got);
			end
		end
	endtask
	// Held until the edge that sees waitrequest low; idle edge after
	task av_xfer(input wr, input [7:0] a, input [31:0] d);
		begin
			av_addr <= a;
			av_wdata <= d;
			av_wr <= wr;
			av_rd <= !wr;
			@(posedge clk);
			while (waitreq !== 1'b0) @(posedge clk);
			rd = av_rdata;
			av_wr <= 1'b0;
			av_rd <= 1'b0;
			@(posedge clk);
		end
	endtask
	task av_write(input [7:0] a, input [31:0] d); av_xfer(1'b1, a, d); endtask
	task av_read(input [7:0] a); av_xfer(1'b0, a, 32'h0); endtask
	task rchk(input [7:0] a, input [31:0] exp, input [8*12-1:0] nm);
		begin
			av_read(a);
			chk(nm, exp, rd);
		end
	endtask
	// Start a command and poll until done or an error flag
	task run(input [15:0] op);
		begin
			av_write(`RERE_REG_CTRL, {16'h0000, op});
			rd = 32'h0;
			while (rd[4:1] == 4'h0) av_read(`RERE_REG_STATE);
		end
	endtask
	// Register rotate against a bit-by-bit model of the bench
	task rot(input [2:0] cf, input dr, input [1:0] sz, input ir, input [31:0] op,
		input [31:0] cr, input x);
		integer j, w, n;
		reg [31:0] r;
		reg xb, o;
		begin
			w = (sz == 2'b00) ? 8 : (sz == 2'b01) ? 16 : 32;
			n = ir ? cr[5:0] : (cf == 3'h0 ? 8 : cf);
			r = op;
			xb = x;
			for (i = 0; i < n; i = i + 1) begin
				o = dr ? r[w-1] : r[0];
				for (j = 1; j < w; j = j + 1)
					r[dr ? w-j : j-1] = r[dr ? w-j-1 : j];
				r[dr ? 0 : w-1] = xb;
				xb = o;
			end
			av_write(`RERE_REG_STATUS_REGISTER, {16'h0, 11'h138, x, 4'hf});
			av_write(`RERE_REG_OPERAND, op);
			av_write(`RERE_REG_CNTREG, cr);
			run({4'he, cf, dr, sz, ir, 5'b10000});
			rchk(`RERE_REG_RESULT, r, "result");
			av_read(`RERE_REG_STATUS_REGISTER);
			e = {16'h0, 11'h138, xb, r[w-1], (r << (32 - w)) == 32'h0, 1'b0, xb};
			chk("flags", e, rd & 32'hffff);
		end
	endtask
	// Memory form: one word read, rotated once, written back
	task memrot(input [15:0] op, input [15:0] w, input x, input [15:0] exp, input [15:0] sr,
		input ill);
		begin
			u_rere_stack_mem.mem[10'h080] = w;
			av_write(`RERE_REG_STATUS_REGISTER, {16'h0, 11'h138, x, 4'h0});
			av_write(`RERE_REG_EA_ADDR, 32'h100);
			run(op);
			chk("illegal", {31'h0, ill}, {31'h0, rd[4]});
			chk("mem_word", {16'h0, exp}, {16'h0, u_rere_stack_mem.mem[10'h080]});
			rchk(`RERE_REG_STATUS_REGISTER, {16'h0, sr}, "mem_flags");
		end
	endtask
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// Watchdog well above the whole sequence
	initial begin
		repeat (40000) @(posedge clk);
		n_fail = n_fail + 1;
		conclude;
	end
	// Main sequence
	initial begin
		n_fail = 0;
		samples_checked = 0;
		rst = 1'b1;
		av_rd = 1'b0;
		av_wr = 1'b0;
		av_addr = 8'h00;
		av_wdata = 32'h0;
		dly = 4'h0;
		fl = 32'h0129ab83;
		wl = {6'h04, 6'h04, 6'h06, 6'h0a, 6'h10, 6'h2e, 6'h00, 6'h00};
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rchk(`RERE_REG_STATUS_REGISTER, 32'h2700, "sr_reset");
		rchk(`RERE_REG_SP, 32'h0, "sp_reset");
		rchk(8'h28, 32'h0, "unmapped");
		rot(3'h0, 1'b1, 2'b00, 1'b0, 32'hffffff81, 32'h0, 1'b1);
		rot(3'h3, 1'b0, 2'b01, 1'b0, 32'h12340001, 32'h0, 1'b0);
		rot(3'h5, 1'b1, 2'b10, 1'b1, 32'h80000000, 32'h41, 1'b1);
		rot(3'h2, 1'b0, 2'b00, 1'b1, 32'h00000080, 32'h40, 1'b1);
		rot(3'h1, 1'b0, 2'b10, 1'b1, 32'ha5a5a5a5, 32'h3f, 1'b0);
		rot(3'h1, 1'b0, 2'b00, 1'b0, 32'h00000001, 32'h0, 1'b0);
		memrot(16'he5d0, 16'h8001, 1'b0, 16'h0002, 16'h2711, 1'b0);
		memrot(16'he4d8, 16'h0001, 1'b1, 16'h8000, 16'h2719, 1'b0);
		memrot(16'he4f9, 16'h0004, 1'b0, 16'h0002, 16'h2700, 1'b0);
		memrot(16'he4c1, 16'h1234, 1'b0, 16'h1234, 16'h2700, 1'b1);
		memrot(16'he4fc, 16'h1234, 1'b1, 16'h1234, 16'h2710, 1'b1);
		memrot(16'he4fa, 16'h1234, 1'b0, 16'h1234, 16'h2700, 1'b1);
		// Returns with a slow memory
		dly <= 4'h3;
		u_rere_stack_mem.mem[10'h100] = 16'h1234;
		u_rere_stack_mem.mem[10'h101] = 16'h5678;
		av_write(`RERE_REG_SP, 32'h200);
		run(`RERE_OP_RET_SUB);
		rchk(`RERE_REG_PC, 32'h12345678, "pc");
		rchk(`RERE_REG_SP, 32'h204, "sp");
		av_write(`RERE_REG_SP, 32'h200);
		av_write(`RERE_REG_EXT, 32'hfff8);
		u_rere_stack_mem.mem[10'h101] = 16'h9abc;
		run(`RERE_OP_RET_DEALLOC);
		rchk(`RERE_REG_SP, 32'h1fc, "sp");
		rchk(`RERE_REG_PC, 32'h12349abc, "pc");
		u_rere_stack_mem.mem[10'h100] = 16'hff1f;
		u_rere_stack_mem.mem[10'h101] = 16'haaaa;
		u_rere_stack_mem.mem[10'h102] = 16'h5555;
		av_write(`RERE_REG_STATUS_REGISTER, 32'h2700);
		av_write(`RERE_REG_SP, 32'h200);
		run(`RERE_OP_RET_FLAGS);
		rchk(`RERE_REG_PC, 32'haaaa5555, "pc");
		rchk(`RERE_REG_STATUS_REGISTER, 32'h271f, "sr");
		rchk(`RERE_REG_SP, 32'h206, "sp");
		// Formats 0, 1, 2, 9, A, B and bad codes 8 and 3, with a short frame behind for the throwaway case
		for (i = 0; i < 8; i = i + 1) begin
			f = fl[31-4*i -: 4];
			u_rere_stack_mem.mem[10'h200] = 16'h2015;
			u_rere_stack_mem.mem[10'h201] = 16'h0000;
			u_rere_stack_mem.mem[10'h202] = 16'h1000;
			u_rere_stack_mem.mem[10'h203] = {f, 12'h000};
			u_rere_stack_mem.mem[10'h204] = 16'h2004;
			u_rere_stack_mem.mem[10'h205] = 16'h0000;
			u_rere_stack_mem.mem[10'h206] = 16'h2000;
			u_rere_stack_mem.mem[10'h207] = 16'h0000;
			av_write(`RERE_REG_STATUS_REGISTER, 32'h2700);
			av_write(`RERE_REG_SP, 32'h400);
			run(`RERE_OP_EXC_RET);
			chk("fmt_err", {31'h0, i > 5}, {31'h0, rd[3]});
			chk("resume", {31'h0, i > 2 && i < 6}, {31'h0, rd[5]});
			e = (i > 5) ? 32'h400 : (i == 1) ? 32'h410 : 32'h400 + 2 * wl[47-6*i -: 6];
			rchk(`RERE_REG_SP, e, "sp");
			e = (i > 5) ? 32'h2700 : (i == 1) ? 32'h2004 : 32'h2015;
			rchk(`RERE_REG_STATUS_REGISTER, e, "sr");
			if (i < 3)
				rchk(`RERE_REG_PC, i == 1 ? 32'h2000 : 32'h1000, "pc");
		end
		av_write(`RERE_REG_STATUS_REGISTER, 32'h0000);
		av_write(`RERE_REG_SP, 32'h400);
		run(`RERE_OP_EXC_RET);
		chk("trap", 32'h1, {31'h0, rd[2]});
		rchk(`RERE_REG_SP, 32'h400, "sp");
		conclude;
	end
endmodule // tb_rere_exec

bind rere_exec rere_exec_monitor u_rere_exec_monitor (.i_core_clk, .i_sys_rst, .i_av_read,
	.i_av_write, .o_av_readdata, .o_av_waitrequest, .o_mem_req, .o_mem_we, .o_mem_addr,
	.i_mem_ack, .o_busy);
